// ### bench/tb_top.sv
// self-checking bench for the windowed watchdog registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
  import wdt_pkg::*;
  logic clock, sys_rst, hsel, hwrite, device_sleep, clr, got;
  logic [31:0] haddr, hwdata, rd, v;
  logic [1:0] htrans, mode;
  logic [2:0] hsize, ccs, cws;
  logic [4:0] cps;
  int n, n_mismatch, n_compared;
  wire logic hreadyout, hresp, watchdog_reset, watchdog_active, wdt_irq;
  wire logic [31:0] hrdata;

  windowed_watchdog_regs i_windowed_watchdog_regs (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .config_enable_mode(mode),
    .config_period_field(cps), .config_clock_field(ccs), .config_window_field(cws),
    .device_sleep(device_sleep), .clear_watchdog_instruction(clr),
    .watchdog_reset(watchdog_reset), .watchdog_active(watchdog_active), .wdt_irq(wdt_irq)
  );

  // ****
  // expectations
  // ****
  function automatic logic [7:0] c0_exp(input logic [4:0] p, input logic [7:0] w, input logic wr);
    return {2'b00, (p != CPS_SW) ? p : (wr ? w[5:1] : PS_DEFAULT), wr ? w[0] : SWEN_RESET};
  endfunction
  function automatic logic [7:0] c1_exp(input logic [2:0] c, input logic [2:0] wn,
    input logic [7:0] w, input logic wr);
    return {1'b0, (c != CCS_SW) ? c : (wr ? w[6:4] : CS_RESET), 1'b0,
      (wn != CWS_SW) ? wn : (wr ? w[2:0] : wn)};
  endfunction
  function automatic int tout(input logic [4:0] p, input logic [2:0] c);
    return 32 * (1 << ((p > PS_MAX) ? 0 : p)) * ((c == CS_MF) ? 800 : 806);
  endfunction

  // ****
  // drivers
  // ****
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'b00};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic do_reset(input logic [1:0] m, input logic [4:0] p, input logic [2:0] c, w);
    @(posedge clock);
    sys_rst <= 1'b1;
    mode <= m;
    cps <= p;
    ccs <= c;
    cws <= w;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic pulse(output logic g);
    repeat (2) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    #1 g = watchdog_reset;
  endtask
  task automatic wait_rst(output int k);
    k = 0;
    while (watchdog_reset !== 1'b1 && k < 40000) begin
      @(posedge clock);
      #1 k++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(40 * 95000);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    {sys_rst, hsel, hwrite, device_sleep, clr} = 5'b10000;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {mode, cps, ccs, cws} = 13'h0;
    v = $urandom(32'h7295bce7);
    // ****
    // writable fields, read-only counters, unmapped place
    // ****
    do_reset(MODE_SW, CPS_SW, CCS_SW, CWS_SW);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, IDX_PSL + 12'(i), 8'hff);
      bus(1'b0, IDX_PSL + 12'(i), 8'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b0, IDX_CTRL0, 8'h0);
    `CHK(rd[7:0], c0_exp(cps, 8'h0, 1'b0))
    bus(1'b0, IDX_CTRL1, 8'h0);
    `CHK(rd[7:0], c1_exp(ccs, cws, 8'h0, 1'b0))
    bus(1'b1, 12'h900, 8'h5a);
    bus(1'b0, 12'h900, 8'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    repeat (4) begin
      v = $urandom;
      bus(1'b1, IDX_CTRL0, v[7:0]);
      bus(1'b0, IDX_CTRL0, 8'h0);
      `CHK(rd[7:0], c0_exp(cps, v[7:0], 1'b1))
      bus(1'b1, IDX_CTRL1, v[15:8]);
      bus(1'b0, IDX_CTRL1, 8'h0);
      `CHK(rd[7:0], c1_exp(ccs, cws, v[15:8], 1'b1))
      `CHK(watchdog_active, v[0])
    end
    // ****
    // fields locked by configuration, mode off
    // ****
    do_reset(2'h0, 5'($urandom_range(30, 0)), 3'($urandom_range(6, 0)), 3'($urandom_range(6, 0)));
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, IDX_CTRL0, 8'h0);
      `CHK(rd[7:0], c0_exp(cps, 8'hff, i[0]))
      bus(1'b0, IDX_CTRL1, 8'h0);
      `CHK(rd[7:0], c1_exp(ccs, cws, 8'hff, i[0]))
      bus(1'b1, IDX_CTRL0, 8'hff);
      bus(1'b1, IDX_CTRL1, 8'hff);
    end
    pulse(got);
    `CHK(got, 1'b0)
    `CHK(watchdog_active, 1'b0)
    // ****
    // awake-only mode stops in sleep
    // ****
    do_reset(MODE_AWAKE, CPS_SW, CCS_SW, CWS_SW);
    `CHK(watchdog_active, 1'b1)
    device_sleep <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(watchdog_active, 1'b0)
    device_sleep <= 1'b0;
    // ****
    // time-out, shortest interval, interrupt raised and cleared
    // ****
    do_reset(MODE_SW, CPS_SW, CCS_SW, CWS_SW);
    bus(1'b1, IDX_IEN, 8'h01);
    bus(1'b1, IDX_CTRL1, 8'h17);
    bus(1'b1, IDX_CTRL0, 8'h01);
    wait_rst(n);
    `CHK(n >= tout(5'h0, CS_MF) * 31 / 32 && n <= tout(5'h0, CS_MF) + 40, 1'b1)
    bus(1'b0, IDX_STAT, 8'h0);
    `CHK(rd[1:0], 2'b01)
    `CHK(wdt_irq, 1'b1)
    bus(1'b1, IDX_ICLR, 8'h01);
    bus(1'b0, IDX_STAT, 8'h0);
    `CHK(rd[1:0], 2'b00)
    `CHK(wdt_irq, 1'b0)
    // ****
    // reserved interval in mode on, interrupt masked
    // ****
    do_reset(MODE_ON, CPS_SW, CCS_SW, CWS_SW);
    bus(1'b1, IDX_CTRL0, 8'h26);
    wait_rst(n);
    `CHK(n >= tout(5'h13, 3'h0) * 31 / 32 && n <= tout(5'h13, 3'h0) + 40, 1'b1)
    bus(1'b0, IDX_STAT, 8'h0);
    `CHK(rd[0], 1'b1)
    `CHK(wdt_irq, 1'b0)
    // ****
    // windowed clears: unarmed, closed, open
    // ****
    do_reset(MODE_SW, CPS_SW, CCS_SW, CWS_SW);
    bus(1'b1, IDX_IEN, 8'h02);
    bus(1'b1, IDX_CTRL1, 8'h06);
    bus(1'b1, IDX_CTRL0, 8'h01);
    pulse(got);
    `CHK(got, 1'b1)
    bus(1'b0, IDX_CTRL0, 8'h0);
    bus(1'b0, IDX_TMR, 8'h0);
    `CHK(rd[2], 1'b1)
    pulse(got);
    `CHK(got, 1'b1)
    bus(1'b0, IDX_CTRL0, 8'h0);
    repeat (6 * 806) @(posedge clock);
    bus(1'b0, IDX_TMR, 8'h0);
    `CHK(rd[7:3] >= 5'h4 && rd[2], 1'b1)
    pulse(got);
    `CHK(got, 1'b0)
    bus(1'b0, IDX_TMR, 8'h0);
    `CHK(rd[2], 1'b0)
    repeat (6 * 806) @(posedge clock);
    bus(1'b1, IDX_CTRL1, 8'h06);
    bus(1'b0, IDX_TMR, 8'h0);
    `CHK(rd[7:3] <= 5'h1, 1'b1)
    bus(1'b0, IDX_STAT, 8'h0);
    `CHK(rd[1:0], 2'b10)
    `CHK(wdt_irq, 1'b1)
    tally_and_finish;
  end
endmodule

// ### bench/wdt_props.sv
// port-level assertion checker for the windowed watchdog
`timescale 1ns/1ps
module wdt_props
  import wdt_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] config_enable_mode,
  input wire logic clear_watchdog_instruction,
  input wire logic watchdog_reset,
  input wire logic watchdog_active
);
  // ****
  // helpers: cycles since release, cycles since counters cleared
  // ****
  logic [3:0] rel_q;
  logic [19:0] run_q;
  wire logic acc = hsel && htrans[1] && hready;
  wire logic ctrl_wr = acc && hwrite && (haddr[13:2] == IDX_CTRL0 || haddr[13:2] == IDX_CTRL1);
  wire logic run_clr = sys_rst || clear_watchdog_instruction || watchdog_reset || !watchdog_active
    || ctrl_wr;
  always_ff @(posedge clock) begin
    if (sys_rst) rel_q <= 4'h0;
    else if (rel_q != 4'hf) rel_q <= rel_q + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (run_clr) run_q <= 20'h0;
    else if (run_q != 20'hfffff) run_q <= run_q + 20'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****
  // assertions
  // ****
  a_one_wait_state: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("transfer without exactly one wait state");
  a_rdata_hold: assert property (!$past(acc, 2) |-> $stable(hrdata))
    else $error("read data changed outside a transfer");
  a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_reset_one_cycle: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_reset_while_on: assert property (watchdog_reset |-> watchdog_active || $past(watchdog_active))
    else $error("watchdog reset while off");
  a_clear_off_quiet: assert property (clear_watchdog_instruction && !watchdog_active
    && !$past(watchdog_active) |=> !watchdog_reset)
    else $error("clear while off caused a reset");
  a_mode_off_idle: assert property (config_enable_mode == 2'h0
    && $past(config_enable_mode, 8) == 2'h0 |-> !watchdog_active)
    else $error("watchdog running in mode off");
  a_mode_on_runs: assert property (config_enable_mode == MODE_ON
    && $past(config_enable_mode, 8) == MODE_ON && rel_q > 4'hb |-> watchdog_active)
    else $error("watchdog not running in mode on");
  a_timeout_late: assert property (watchdog_reset && !$past(clear_watchdog_instruction)
    |-> run_q >= 20'd24800)
    else $error("time-out earlier than the shortest interval");
endmodule

bind windowed_watchdog_regs wdt_props i_wdt_props (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .config_enable_mode(config_enable_mode),
  .clear_watchdog_instruction(clear_watchdog_instruction),
  .watchdog_reset(watchdog_reset), .watchdog_active(watchdog_active)
);

// ### design/ahb_reg_slave.sv
// ahb-lite slave with one wait state per transfer
`timescale 1ns/1ps
module ahb_reg_slave (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  reg_if.bus regs
);
  import wdt_pkg::*;

  bus_state_e state_q;
  logic [11:0] idx_q;
  logic write_q;
  logic hit_q;

  wire take = hsel & htrans[1] & hready;
  // word access inside the 16 kB block only
  wire hit = (haddr[31:14] == 18'h0) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);
  wire in_data = (state_q == BUS_DATA);

  assign regs.wr = in_data & write_q & hit_q;
  assign regs.rd = in_data & ~write_q & hit_q;
  assign regs.idx = idx_q;
  assign regs.wdata = hwdata[7:0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= BUS_IDLE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      idx_q <= 12'h0;
      write_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (take) begin
            state_q <= BUS_DATA;
            hreadyout <= 1'b0;
            idx_q <= haddr[13:2];
            write_q <= hwrite;
            hit_q <= hit;
          end
        end
        BUS_DATA: begin
          state_q <= BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata <= regs.rd ? {24'h0, regs.rdata} : 32'h0;
        end
        default: begin
          state_q <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ### design/reg_if.sv
// register access carrier between bus slave and watchdog core
`timescale 1ns/1ps
interface reg_if;
  logic wr;
  logic rd;
  logic [11:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr, output rd, output idx, output wdata, input rdata);
  modport core (input wr, input rd, input idx, input wdata, output rdata);
endinterface

// ### design/wdt_pkg.sv
// constants, register map and state codes of the windowed watchdog
package wdt_pkg;
  // ****************************************
  // time base
  // ****************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned OSC_LF_HZ = 31000;
  localparam int unsigned OSC_MF_HZ = 31250;
  localparam logic [9:0] DIV_LF = 10'(CLK_HZ / OSC_LF_HZ);
  localparam logic [9:0] DIV_MF = 10'(CLK_HZ / OSC_MF_HZ);
  localparam logic [2:0] INIT_CYCLES = 3'h5;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [11:0] IDX_CTRL0 = 12'h80c;
  localparam logic [11:0] IDX_CTRL1 = 12'h80d;
  localparam logic [11:0] IDX_PSL = 12'h80e;
  localparam logic [11:0] IDX_PSH = 12'h80f;
  localparam logic [11:0] IDX_TMR = 12'h810;
  localparam logic [11:0] IDX_STAT = 12'h811;
  localparam logic [11:0] IDX_ICLR = 12'h812;
  localparam logic [11:0] IDX_IEN = 12'h813;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 5;
  localparam int SWEN_BIT = 0;
  localparam int CS_LSB = 4;
  localparam int CS_MSB = 6;
  localparam int WIN_LSB = 0;
  localparam int WIN_MSB = 2;

  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [4:0] PS_DEFAULT = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam logic [4:0] PS_MIN = 5'h00;
  localparam logic [4:0] CPS_SW = 5'h1f;
  localparam logic [2:0] CCS_SW = 3'h7;
  localparam logic [2:0] CWS_SW = 3'h7;
  localparam logic [2:0] CS_RESET = 3'h0;
  localparam logic [2:0] CS_MF = 3'h1;
  localparam logic [2:0] WIN_FULL = 3'h7;
  localparam logic SWEN_RESET = 1'b0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  localparam logic [4:0] TMR_MAX = 5'h1f;
  localparam int CFG_W = 13;
  localparam int EV_W = 2;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_VIOL = 1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_e;
endpackage

// ### design/wdt_timebase.sv
// oscillator tick divider, prescale counter and window counter
`timescale 1ns/1ps
module wdt_timebase (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic clear,
  input wire logic clk_mf,
  input wire logic [4:0] interval,
  output logic [17:0] prescale_count,
  output logic [4:0] window_counter,
  output logic timeout
);
  import wdt_pkg::*;

  logic [9:0] div_q;

  wire [9:0] div_last = clk_mf ? (DIV_MF - 10'h1) : (DIV_LF - 10'h1);
  wire osc_tick = (div_q == div_last);
  // one window step is 1/32 of the interval: 2^code oscillator ticks
  wire [17:0] step_last = 18'((19'h1 << interval) - 19'h1);
  wire step_done = osc_tick & (prescale_count == step_last);

  always_ff @(posedge clock) begin
    if (sys_rst | clear | ~run) begin
      div_q <= 10'h0;
      prescale_count <= 18'h0;
      window_counter <= 5'h0;
      timeout <= 1'b0;
    end else begin
      div_q <= osc_tick ? 10'h0 : div_q + 10'h1;
      timeout <= step_done & (window_counter == TMR_MAX);
      if (step_done) begin
        prescale_count <= 18'h0;
        window_counter <= window_counter + 5'h1;
      end else if (osc_tick) begin
        prescale_count <= prescale_count + 18'h1;
      end
    end
  end
endmodule

// ### design/windowed_watchdog_regs.sv
// windowed watchdog: control registers, window check and interrupts
`timescale 1ns/1ps
// How it works
// - interval code 0 divides by 32, each step doubles, up to 2^23 at 10010
// - interval codes 10011 to 11111 run at the shortest interval
// - interval code 01011 divides by 65536 and is the default
// - interval loads 01011 if config period is 11111, else config period
// - interval is read-only unless config period is 11111
// - software enable bit 0 turns the watchdog on only in mode 01
// - clock select 000 picks the 31 kHz, 001 the 31.25 kHz oscillator
// - clock select loads 000 if config clock is 111, else config clock, and is writable only if config clock is 111
// - window select opens the last (code+1) eighths of the period
// - window select loads config window, writable only if that is 111
// - window counter in timer bits 7:3, closed below 4*(7-code)
// - timer bit 2 reads the armed flag
// - 18-bit prescale count readable in low, high and timer bits 1:0
// - prescale and timer registers are read-only, reset to zero
// - windowed mode needs a control zero read before a clear
// - a clear outside the open window resets like a time-out
// - writes to either control register clear the counters
module windowed_watchdog_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] config_enable_mode,
  input wire logic [4:0] config_period_field,
  input wire logic [2:0] config_clock_field,
  input wire logic [2:0] config_window_field,
  input wire logic device_sleep,
  input wire logic clear_watchdog_instruction,
  output logic watchdog_reset,
  output logic watchdog_active,
  output logic wdt_irq
);
  import wdt_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  reg_if regs_bus ();

  logic [wdt_pkg::CFG_W-1:0] cfg_s1_q;
  logic [wdt_pkg::CFG_W-1:0] cfg_s2_q;
  logic [wdt_pkg::CFG_W-1:0] cfg_s3_q;
  logic [wdt_pkg::CFG_W-1:0] cfg_q;
  logic [2:0] init_q;
  logic [4:0] interval_select_q;
  logic software_enable_bit_q;
  logic [2:0] clock_select_q;
  logic [2:0] window_select_q;
  logic armed_q;
  logic [wdt_pkg::EV_W-1:0] status_q;
  logic [wdt_pkg::EV_W-1:0] irq_en_q;
  logic [17:0] prescale_count;
  logic [4:0] window_counter;
  logic timeout;

  // ****************************************
  // configuration word capture
  // ****************************************
  wire [wdt_pkg::CFG_W-1:0] cfg_raw = {config_enable_mode, config_period_field,
                                       config_clock_field, config_window_field};

  genvar gi;
  generate
    for (gi = 0; gi < CFG_W; gi = gi + 1) begin : g_cfg_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          cfg_s1_q[gi] <= 1'b0;
          cfg_s2_q[gi] <= 1'b0;
          cfg_s3_q[gi] <= 1'b0;
          cfg_q[gi] <= 1'b0;
        end else begin
          cfg_s1_q[gi] <= cfg_raw[gi];
          cfg_s2_q[gi] <= cfg_s1_q[gi];
          cfg_s3_q[gi] <= cfg_s2_q[gi];
          if (cfg_s2_q[gi] == cfg_s3_q[gi]) begin
            cfg_q[gi] <= cfg_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire [1:0] cfg_mode = cfg_q[12:11];
  wire [4:0] cfg_period = cfg_q[10:6];
  wire [2:0] cfg_clock = cfg_q[5:3];
  wire [2:0] cfg_window = cfg_q[2:0];
  // control fields keep loading until the captured word has settled
  wire init_done = (init_q == INIT_CYCLES);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      init_q <= 3'h0;
    end else if (!init_done) begin
      init_q <= init_q + 3'h1;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  ahb_reg_slave u_slave (
    .clock(clock),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(regs_bus)
  );

  wire wr_ctrl0 = regs_bus.wr & (regs_bus.idx == IDX_CTRL0);
  wire wr_ctrl1 = regs_bus.wr & (regs_bus.idx == IDX_CTRL1);
  wire wr_iclr = regs_bus.wr & (regs_bus.idx == IDX_ICLR);
  wire wr_ien = regs_bus.wr & (regs_bus.idx == IDX_IEN);
  wire rd_ctrl0 = regs_bus.rd & (regs_bus.idx == IDX_CTRL0);
  wire [7:0] wd = regs_bus.wdata;

  // ****************************************
  // writable fields and their reset values
  // ****************************************
  wire ps_writable = (cfg_period == CPS_SW);
  wire cs_writable = (cfg_clock == CCS_SW);
  wire win_writable = (cfg_window == CWS_SW);
  wire [4:0] ps_load = ps_writable ? PS_DEFAULT : cfg_period;
  wire [2:0] cs_load = cs_writable ? CS_RESET : cfg_clock;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interval_select_q <= PS_DEFAULT;
      software_enable_bit_q <= SWEN_RESET;
      clock_select_q <= CS_RESET;
      window_select_q <= WIN_FULL;
    end else if (!init_done) begin
      interval_select_q <= ps_load;
      software_enable_bit_q <= SWEN_RESET;
      clock_select_q <= cs_load;
      window_select_q <= cfg_window;
    end else begin
      if (wr_ctrl0) begin
        software_enable_bit_q <= wd[SWEN_BIT];
      end
      if (wr_ctrl0 && ps_writable) begin
        interval_select_q <= wd[PS_MSB:PS_LSB];
      end
      if (wr_ctrl1 && cs_writable) begin
        clock_select_q <= wd[CS_MSB:CS_LSB];
      end
      if (wr_ctrl1 && win_writable) begin
        window_select_q <= wd[WIN_MSB:WIN_LSB];
      end
    end
  end

  // ****************************************
  // mode, interval and window decode
  // ****************************************
  wire mode_sw_on = (cfg_mode == MODE_SW) & software_enable_bit_q;
  wire mode_awake_on = (cfg_mode == MODE_AWAKE) & ~device_sleep;
  wire active = init_done & ((cfg_mode == MODE_ON) | mode_awake_on | mode_sw_on);
  wire [4:0] interval_eff = (interval_select_q > PS_MAX) ? PS_MIN : interval_select_q;
  wire clk_mf = (clock_select_q == CS_MF);
  wire windowed = (window_select_q != WIN_FULL);
  wire [2:0] closed_eighths = WIN_FULL - window_select_q;
  wire [4:0] open_from = {closed_eighths, 2'b00};
  wire window_open = (window_counter >= open_from);

  // ****************************************
  // clear instruction and window check
  // ****************************************
  wire clr = clear_watchdog_instruction & active;
  wire violation = clr & windowed & (~armed_q | ~window_open);
  wire valid_clear = clr & ~violation;
  wire fire = active & (violation | timeout);
  wire counter_clear = valid_clear | wr_ctrl0 | wr_ctrl1 | fire;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= rd_ctrl0 | (armed_q & ~clr);
    end
  end

  wdt_timebase u_timebase (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(active),
    .clear(counter_clear),
    .clk_mf(clk_mf),
    .interval(interval_eff),
    .prescale_count(prescale_count),
    .window_counter(window_counter),
    .timeout(timeout)
  );

  // ****************************************
  // events, interrupt and outputs
  // ****************************************
  wire [wdt_pkg::EV_W-1:0] events = {active & violation, active & timeout};
  wire [wdt_pkg::EV_W-1:0] clr_mask = wr_iclr ? wd[EV_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [wdt_pkg::EV_W-1:0] status_d = events | (status_q & ~clr_mask);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q <= '0;
      irq_en_q <= '0;
      wdt_irq <= 1'b0;
      watchdog_reset <= 1'b0;
      watchdog_active <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_ien) begin
        irq_en_q <= wd[EV_W-1:0];
      end
      wdt_irq <= |(status_q & irq_en_q);
      watchdog_reset <= fire;
      watchdog_active <= active;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] rd_ctrl0_v = {2'b00, interval_select_q, software_enable_bit_q};
  wire [7:0] rd_ctrl1_v = {1'b0, clock_select_q, 1'b0, window_select_q};
  wire [7:0] rd_tmr_v = {window_counter, armed_q, prescale_count[17:16]};
  wire [7:0] rd_stat_v = {6'h0, status_q};
  wire [7:0] rd_ien_v = {6'h0, irq_en_q};

  // prescale and timer registers have no write path
  assign regs_bus.rdata = (regs_bus.idx == IDX_CTRL0) ? rd_ctrl0_v :
                          (regs_bus.idx == IDX_CTRL1) ? rd_ctrl1_v :
                          (regs_bus.idx == IDX_PSL) ? prescale_count[7:0] :
                          (regs_bus.idx == IDX_PSH) ? prescale_count[15:8] :
                          (regs_bus.idx == IDX_TMR) ? rd_tmr_v :
                          (regs_bus.idx == IDX_STAT) ? rd_stat_v :
                          (regs_bus.idx == IDX_IEN) ? rd_ien_v : 8'h00;
endmodule
